//--- bench/cdps_gate_model.sv
`timescale 1ns/1ps

// ==========================================================
// Gate driver pair: counts turn-on pulses, flags both switches on
module cdps_gate_model (
    input  wire logic i_clock,
    input  wire logic i_high_side_drive,
    input  wire logic i_low_side_drive,
    output int        o_high_pulses,
    output int        o_low_pulses,
    output int        o_overlaps
);
    logic high_reg;
    logic low_reg;

    // Start from switches off, as a real driver does at power-up
    initial begin
        high_reg      = 1'b0;
        low_reg       = 1'b0;
        o_high_pulses = 0;
        o_low_pulses  = 0;
        o_overlaps    = 0;
    end

    // Both switches on at once would short the input supply
    always @(posedge i_clock) begin
        high_reg <= i_high_side_drive;
        low_reg  <= i_low_side_drive;
        if (i_high_side_drive === 1'b1 && high_reg === 1'b0) o_high_pulses <= o_high_pulses + 1;
        if (i_low_side_drive === 1'b1 && low_reg === 1'b0) o_low_pulses <= o_low_pulses + 1;
        if (i_high_side_drive === 1'b1 && i_low_side_drive === 1'b1) o_overlaps <= o_overlaps + 1;
    end
endmodule : cdps_gate_model

//--- bench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import cdps_pkg::*;

    localparam int PER = 20;

    typedef struct packed {
        logic [DATA_W-1:0] exp;
        logic [DATA_W-1:0] mask;
    } cdps_note_t;

    logic              i_clock;
    logic              i_reset;
    logic              i_clock_en;
    logic              i_enable;
    logic              i_mode;
    logic              i_fault_n;
    logic              i_thermal_shutdown;
    logic              i_supply_good;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata;
    logic              i_write;
    logic              i_read;
    logic [DATA_W-1:0] o_rdata;
    logic              o_irq;
    logic              o_high_side_drive;
    logic              o_low_side_drive;
    int                n_errors;
    int                n_tests;
    int                w;
    int                gap;
    int                w_early;
    int                hi_n;
    int                lo_n;
    int                ovl_n;
    logic              rd_seen;
    logic [DATA_W-1:0] rnd;
    logic [DATA_W-1:0] ev;
    cdps_note_t        notes[$];
    cdps_note_t        note;

    cdps_top #(.PERIOD(PER)) DUT (
        .i_clock(i_clock), .i_reset(i_reset), .i_clock_en(i_clock_en),
        .i_enable(i_enable), .i_mode(i_mode), .i_fault_n(i_fault_n),
        .i_thermal_shutdown(i_thermal_shutdown), .i_supply_good(i_supply_good),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
        .o_rdata(o_rdata), .o_irq(o_irq), .o_high_side_drive(o_high_side_drive),
        .o_low_side_drive(o_low_side_drive)
    );

    cdps_gate_model gates (
        .i_clock(i_clock), .i_high_side_drive(o_high_side_drive),
        .i_low_side_drive(o_low_side_drive), .o_high_pulses(hi_n),
        .o_low_pulses(lo_n), .o_overlaps(ovl_n)
    );

    // ==========================================================
    // Clock, 25 ns period
    initial i_clock = 1'b0;
    always #12.5 i_clock = ~i_clock;

    // ==========================================================
    // Helpers
    task automatic chk(input string name, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", name, e, g);
            n_errors++;
        end
    endtask : chk

    task automatic end_sim;
        $display("errors %0d comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clock);
        i_write <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask : wr

    // Notes the expected word; the monitor compares when it appears
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                          input logic [DATA_W-1:0] m);
        notes.push_back('{exp: e, mask: m});
        @(posedge i_clock);
        i_read <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_read <= 1'b0;
    endtask : rd_chk

    task automatic pins(input logic en, input logic md, input logic fn, input logic ts,
                        input logic gd);
        @(posedge i_clock);
        i_enable           <= en;
        i_mode             <= md;
        i_fault_n          <= fn;
        i_thermal_shutdown <= ts;
        i_supply_good      <= gd;
    endtask : pins

    function automatic logic drv(input logic s);
        return s ? o_high_side_drive : o_low_side_drive;
    endfunction : drv

    function automatic logic [DATA_W-1:0] stat(input logic m, input logic [1:0] ph);
        return (DATA_W'(m) << STAT_MODE_BIT) | (DATA_W'(1) << STAT_RUN_BIT)
             | (DATA_W'(ph) << STAT_PHASE_LSB);
    endfunction : stat

    task automatic quiet(input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            @(posedge i_clock);
            if (o_high_side_drive !== 1'b0 || o_low_side_drive !== 1'b0) bad++;
        end
        chk("drives idle", 0, bad);
    endtask : quiet

    // Width of one pulse of drive s, cycles from its rise to the other's rise
    task automatic meas(input logic s, output int wd, output int gp);
        int k;
        k  = 0;
        gp = -1;
        wd = 0;
        while (drv(s) !== 1'b1 && k < 10 * PER) begin
            @(posedge i_clock);
            k++;
        end
        if (drv(s) !== 1'b1) return;
        wd = 1;
        for (k = 1; k <= PER + 1; k++) begin
            @(posedge i_clock);
            if (drv(s) === 1'b1 && wd < k) break;
            if (drv(s) === 1'b1) wd++;
            if (drv(!s) === 1'b1 && gp < 0) gp = k;
        end
    endtask : meas

    task automatic wait_on(input logic s, input int n);
        while (drv(s) !== 1'b1 && n > 0) begin
            @(posedge i_clock);
            n--;
        end
        chk("drive started", 1, drv(s));
    endtask : wait_on

    // Read data stand one cycle after the read strobe
    always @(posedge i_clock) begin
        if (rd_seen === 1'b1) begin
            note = notes.pop_front();
            chk("read data", note.exp, o_rdata & note.mask);
        end
        rd_seen <= i_read;
    end

    // Watchdog
    initial begin
        repeat (40000) @(posedge i_clock);
        n_errors++;
        end_sim();
    end

    // ==========================================================
    // Main sequence
    initial begin
        {i_enable, i_mode, i_thermal_shutdown, i_supply_good, i_write, i_read} = '0;
        {i_addr, i_wdata} = '0;
        {n_errors, n_tests} = '0;
        i_reset    = 1'b1;
        i_clock_en = 1'b1;
        i_fault_n  = 1'b1;
        rd_seen    = 1'b0;
        rnd = $urandom(32'hbc9414c1);
        repeat (2) @(posedge i_clock);
        i_reset <= 1'b0;
        // Reset values, unmapped read, random write-back
        rd_chk(ADR_CTRL, 32'h0000_0001, '1);
        rd_chk(ADR_DUTY, 32'h0000_FFFF, '1);
        rd_chk(ADR_SS_STEP, 32'h0000_0028, '1);
        rd_chk(ADR_IRQ_MSK, 32'h0000_0000, '1);
        rd_chk(8'h18, 32'h0000_0000, '1);
        rnd = $urandom & 32'h0000_FFFF;
        wr(ADR_DUTY, rnd);
        rd_chk(ADR_DUTY, rnd, '1);
        wr(ADR_DUTY, 32'h0000_FFFF);
        wr(ADR_SS_STEP, 32'h0000_0000);
        wr(ADR_IRQ_MSK, 32'h0000_001F);
        // Charge start: idle, nonsync high side, then sync
        pins(1, 1, 1, 0, 1);
        quiet(400);
        meas(1, w, gap);
        meas(1, w_early, gap);
        chk("early width", 2, w_early);
        chk("nonsync partner", '1, gap);
        rd_chk(ADR_STATUS, stat(1, 2'd2), 32'h0000_000F);
        repeat (2000) @(posedge i_clock);
        meas(1, w, gap);
        chk("width grows", 1, w > w_early && w <= PER);
        wr(ADR_DUTY, 32'h0000_0005);
        wait_on(0, 3000);
        meas(1, w, gap);
        chk("sync width", 5, w);
        chk("charge order", 7, gap);
        rd_chk(ADR_STATUS, stat(1, 2'd3), 32'h0000_000F);
        rd_chk(ADR_IRQ_ST, 32'h0000_0008, 32'h0000_0008);
        // Mode pin moves while running
        pins(1, 0, 1, 0, 1);
        repeat (10) @(posedge i_clock);
        meas(1, w, gap);
        chk("mode held", 7, gap);
        // Clock enable low freezes the drive in mid-pulse
        i_clock_en <= 1'b0;
        repeat (30) @(posedge i_clock);
        chk("frozen drive", 1, o_high_side_drive);
        i_clock_en <= 1'b1;
        // Fault: drives off, ramp cleared, interrupt raised, masked, cleared
        pins(1, 0, 0, 0, 1);
        repeat (4) @(posedge i_clock);
        quiet(50);
        rd_chk(ADR_STATUS, 32'h0000_0000, 32'h1FFF_000F);
        rd_chk(ADR_IRQ_ST, 32'h0000_0001, 32'h0000_0001);
        @(posedge i_clock);
        chk("irq raised", 1, o_irq);
        wr(ADR_IRQ_MSK, 32'h0000_0000);
        @(posedge i_clock);
        chk("irq masked", 0, o_irq);
        wr(ADR_IRQ_ST, 32'h0000_001F);
        wr(ADR_IRQ_MSK, 32'h0000_001F);
        @(posedge i_clock);
        chk("irq cleared", 0, o_irq);
        // Fault release recaptures discharge
        pins(1, 0, 1, 0, 1);
        quiet(400);
        meas(0, w, gap);
        meas(0, w, gap);
        chk("discharge nonsync", '1, gap);
        wait_on(1, 5000);
        meas(0, w, gap);
        chk("discharge order", 7, gap);
        rd_chk(ADR_STATUS, stat(0, 2'd3), 32'h0000_000F);
        // Thermal, supply, enable: stop, mode change while off, fresh start
        for (int i = 0; i < 3; i++) begin
            ev = 32'h0000_0001 << (i == 0 ? IRQ_TSD_BIT : i == 1 ? IRQ_SUPPLY_UNDERVOLTAGE_LOCKOUT_BIT : IRQ_DIS_BIT);
            pins(i != 2, i == 1, 1, i == 0, i != 1);
            repeat (4) @(posedge i_clock);
            quiet(30);
            rd_chk(ADR_STATUS, DATA_W'(i == 1), 32'h1FFF_000F);
            rd_chk(ADR_IRQ_ST, ev, ev);
            pins(i != 2, i != 1, 1, i == 0, i != 1);
            repeat (5) @(posedge i_clock);
            pins(1, i != 1, 1, 0, 1);
            quiet(400);
            meas(i != 1, w, gap);
            meas(i != 1, w, gap);
            chk("restart main", 1, w > 0);
            chk("restart nonsync", '1, gap);
        end
        repeat (4) @(posedge i_clock);
        chk("shoot through", 0, ovl_n);
        chk("pulses seen", 1, hi_n > 0 && lo_n > 0);
        end_sim();
    end
endmodule : tb_top

//--- hw/cdps_pin_if.sv
`timescale 1ns/1ps

// ==========================================================
// Raw pins in, synchronised levels out
interface cdps_pin_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport src (output raw, input synced);
    modport snk (input raw, output synced);
endinterface : cdps_pin_if

//--- hw/cdps_pkg.sv
package cdps_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int SS_W   = 13;
    localparam int STEP_W = 16;
    localparam int IRQ_W  = 5;
    localparam int PIN_W  = 5;

    // ==========================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADR_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] ADR_DUTY    = 8'h04;
    localparam logic [ADDR_W-1:0] ADR_SS_STEP = 8'h08;
    localparam logic [ADDR_W-1:0] ADR_STATUS  = 8'h0C;
    localparam logic [ADDR_W-1:0] ADR_IRQ_ST  = 8'h10;
    localparam logic [ADDR_W-1:0] ADR_IRQ_MSK = 8'h14;

    // ==========================================================
    // Field positions
    localparam int CTRL_RUN_BIT   = 0;
    localparam int STAT_MODE_BIT  = 0;
    localparam int STAT_RUN_BIT   = 1;
    localparam int STAT_PHASE_LSB = 2;
    localparam int STAT_SS_LSB    = 16;
    localparam int IRQ_FAULT_BIT  = 0;
    localparam int IRQ_TSD_BIT    = 1;
    localparam int IRQ_SUPPLY_UNDERVOLTAGE_LOCKOUT_BIT   = 2;
    localparam int IRQ_SYNC_BIT   = 3;
    localparam int IRQ_DIS_BIT    = 4;

    // ==========================================================
    // Pin vector positions
    localparam int PIN_EN    = 4;
    localparam int PIN_MODE  = 3;
    localparam int PIN_FLT_N = 2;
    localparam int PIN_TSD   = 1;
    localparam int PIN_GOOD  = 0;

    // ==========================================================
    // Reset values
    localparam logic [CNT_W-1:0]  DUTY_RST    = 16'hFFFF;
    localparam logic [STEP_W-1:0] SS_STEP_RST = 16'h0028;

    // ==========================================================
    // Soft-start ramp levels in millivolts
    localparam logic [SS_W-1:0] SS_TH1_MV  = 13'h0208;
    localparam logic [SS_W-1:0] SS_TH2_MV  = 13'h1194;
    localparam logic [SS_W-1:0] SS_FULL_MV = 13'h1388;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int CLOCK_KHZ     = 40000;
    localparam int PWM_FREQ_KHZ  = 200;
    localparam int PERIOD_CYC    = CLOCK_KHZ / PWM_FREQ_KHZ;
    localparam int DEAD_TIME_NS  = 50;
    localparam int DEAD_CYC      = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Phases and state
    typedef enum logic [1:0] {
        PH_OFF,
        PH_WAIT,
        PH_NONSYNC,
        PH_SYNC
    } cdps_phase_t;

    typedef struct packed {
        logic                 en_q;
        logic                 fault_n_q;
        logic                 tsd_q;
        logic                 good_q;
        logic                 mode;
        cdps_phase_t          phase;
        logic [SS_W-1:0]      ss;
        logic [STEP_W-1:0]    step_cnt;
        logic [CNT_W-1:0]     cnt;
        logic                 hs;
        logic                 ls;
        logic [CNT_W-1:0]     duty;
        logic [STEP_W-1:0]    ss_step;
        logic                 ctrl_run;
        logic [IRQ_W-1:0]     irq_st;
        logic [IRQ_W-1:0]     irq_mask;
        logic [DATA_W-1:0]    rdata;
    } cdps_state_t;

endpackage : cdps_pkg

//--- hw/cdps_sync.sv
`timescale 1ns/1ps

module cdps_sync #(
    parameter int W = 1
) (
    input  wire logic i_clock,
    input  wire logic i_reset,
    input  wire logic i_clock_en,
    cdps_pin_if.snk   pins
);
    import cdps_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cdps_sync_state_t;

    cdps_sync_state_t st_reg;
    cdps_sync_state_t st_next;

    // ==========================================================
    // Two-stage synchroniser; only the second stage leaves
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = pins.raw;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            st_reg <= '0;
        end else if (i_clock_en) begin
            st_reg <= st_next;
        end
    end

    assign pins.synced = st_reg.s2;

endmodule : cdps_sync

//--- hw/cdps_top.sv
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// R1 - Mode input high means charge, low means discharge.
// R2 - Enable rising edge captures mode; mode then held while enabled.
// R3 - Fault input returning high also recaptures mode, held while enabled.
// R4 - Mode may change only while disabled by enable, fault, thermal or undervoltage. The code also lets mode follow the pin while the CTRL run bit is clear.
// R5 - Controller drops enable, changes mode, then raises enable again.
// R6 - Charge: high-side pulse first; discharge: low-side pulse first.
// R7 - Charge runs as buck, discharge runs as boost.
// R8 - Enable low stops switching and holds both drives low.
// R9 - Thermal shutdown, undervoltage or fault input low also stop switching.
// R10 - No switching until supply good; stop again only when it drops.
// R11 - Enable rising starts a linearly rising soft-start ramp.
// R12 - Below first ramp threshold both drives stay low.
// R13 - Past first threshold, only the mode's main switch runs, duty growing.
// R14 - Past upper threshold, both drives switch in mode order.
// R15 - Permitted duty rises in proportion to the ramp level.
// R16 - Fault low discharges ramp; fault high resumes with fresh soft start.
// R17 - Thermal shutdown forces drives low and resets ramp until it clears.
// R18 - Any disable resets the ramp so re-enable starts a new soft start.
module cdps_top #(
    parameter int unsigned PERIOD = cdps_pkg::PERIOD_CYC
) (
    input  wire logic                         i_clock,
    input  wire logic                         i_reset,
    input  wire logic                         i_clock_en,
    input  wire logic                         i_enable,
    input  wire logic                         i_mode,
    input  wire logic                         i_fault_n,
    input  wire logic                         i_thermal_shutdown,
    input  wire logic                         i_supply_good,
    input  wire logic [cdps_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [cdps_pkg::DATA_W-1:0]  i_wdata,
    input  wire logic                         i_write,
    input  wire logic                         i_read,
    output logic      [cdps_pkg::DATA_W-1:0]  o_rdata,
    output logic                              o_irq,
    output logic                              o_high_side_drive,
    output logic                              o_low_side_drive
);
    import cdps_pkg::*;

    // ==========================================================
    // Declarations
    cdps_state_t        st_reg;
    cdps_state_t        st_next;
    logic               en_s;
    logic               mode_s;
    logic               fault_n_s;
    logic               tsd_s;
    logic               good_s;
    logic               run;
    logic               en_rise;
    logic               fault_rise;
    logic [CNT_W-1:0]   ramp_lim;
    logic [CNT_W-1:0]   lim;
    logic               main_on;
    logic               partner_on;
    logic [IRQ_W-1:0]   events;
    logic [IRQ_W-1:0]   w1c;
    logic [DATA_W-1:0]  status_word;

    cdps_pin_if #(.W(PIN_W)) pins ();

    // ==========================================================
    // Pin synchronisers
    assign pins.raw = {i_enable, i_mode, i_fault_n, i_thermal_shutdown, i_supply_good};

    cdps_sync #(
        .W (PIN_W)
    ) u_sync (
        .i_clock    (i_clock),
        .i_reset    (i_reset),
        .i_clock_en (i_clock_en),
        .pins       (pins)
    );

    assign en_s      = pins.synced[PIN_EN];
    assign mode_s    = pins.synced[PIN_MODE];
    assign fault_n_s = pins.synced[PIN_FLT_N];
    assign tsd_s     = pins.synced[PIN_TSD];
    assign good_s    = pins.synced[PIN_GOOD];

    // ==========================================================
    // Enable gate and edge detection
    assign run        = en_s & fault_n_s & ~tsd_s & good_s & st_reg.ctrl_run; // R8 R9 R10
    assign en_rise    = en_s & ~st_reg.en_q;
    assign fault_rise = fault_n_s & ~st_reg.fault_n_q;

    // ==========================================================
    // Duty limits and switch timing
    assign ramp_lim = CNT_W'((32'(st_reg.ss) * 32'(PERIOD)) / 32'(SS_FULL_MV)); // R15
    assign lim      = (st_reg.duty < ramp_lim) ? st_reg.duty : ramp_lim;

    // Main switch leads each period; partner waits a dead time after it
    assign main_on    = ((st_reg.phase == PH_NONSYNC) || (st_reg.phase == PH_SYNC))
                        && (st_reg.cnt < lim); // R12 R13
    assign partner_on = (st_reg.phase == PH_SYNC)
                        && ({1'b0, st_reg.cnt} >= ({1'b0, lim} + 17'(DEAD_CYC)))
                        && (st_reg.cnt < CNT_W'(PERIOD - DEAD_CYC)); // R14

    // ==========================================================
    // Interrupt sources
    assign events[IRQ_FAULT_BIT] = st_reg.fault_n_q & ~fault_n_s;
    assign events[IRQ_TSD_BIT]   = tsd_s & ~st_reg.tsd_q;
    assign events[IRQ_SUPPLY_UNDERVOLTAGE_LOCKOUT_BIT]  = st_reg.good_q & ~good_s;
    // Same condition as the phase step into sync, taken from registers only
    assign events[IRQ_SYNC_BIT]  = run && (st_reg.phase == PH_NONSYNC)
                                   && (st_reg.ss > SS_TH2_MV);
    assign events[IRQ_DIS_BIT]   = st_reg.en_q & ~en_s;

    assign w1c = (i_write && (i_addr == ADR_IRQ_ST)) ? i_wdata[IRQ_W-1:0] : '0;

    // Status word for readback
    always_comb begin
        status_word                                = '0;
        status_word[STAT_MODE_BIT]                 = st_reg.mode;
        status_word[STAT_RUN_BIT]                  = run;
        status_word[STAT_PHASE_LSB +: 2]           = st_reg.phase;
        status_word[STAT_SS_LSB +: SS_W]           = st_reg.ss;
    end

    // ==========================================================
    // Next-state logic
    always_comb begin
        st_next           = st_reg;
        st_next.en_q      = en_s;
        st_next.fault_n_q = fault_n_s;
        st_next.tsd_q     = tsd_s;
        st_next.good_q    = good_s;
        st_next.rdata     = '0;

        // Mode follows the pin while disabled, frozen once running
        if (!run || en_rise || fault_rise) begin
            st_next.mode = mode_s; // R1 R2 R3 R4
        end

        // Phase sequencing and ramp
        if (!run) begin
            st_next.phase    = PH_OFF; // R16 R17
            st_next.ss       = '0; // R18
            st_next.step_cnt = '0;
            st_next.cnt      = '0;
        end else begin
            if (st_reg.ss < SS_FULL_MV) begin
                if (st_reg.step_cnt >= st_reg.ss_step) begin
                    st_next.step_cnt = '0;
                    st_next.ss       = st_reg.ss + 13'h1; // R11
                end else begin
                    st_next.step_cnt = st_reg.step_cnt + 16'h1;
                end
            end
            if (st_reg.cnt >= CNT_W'(PERIOD - 1)) begin
                st_next.cnt = '0;
            end else begin
                st_next.cnt = st_reg.cnt + 16'h1;
            end
            case (st_reg.phase)
                PH_OFF: begin
                    st_next.phase = PH_WAIT; // R11
                end
                PH_WAIT: begin
                    if (st_reg.ss >= SS_TH1_MV) begin
                        st_next.phase = PH_NONSYNC; // R13
                    end
                end
                PH_NONSYNC: begin
                    if (st_reg.ss > SS_TH2_MV) begin
                        st_next.phase = PH_SYNC; // R14
                    end
                end
                PH_SYNC: begin
                    st_next.phase = PH_SYNC;
                end
                default: begin
                    st_next.phase = PH_OFF;
                end
            endcase
        end

        // Drive steering: buck leads with high side, boost with low side
        if (!run) begin
            st_next.hs = 1'b0; // R8 R9
            st_next.ls = 1'b0;
        end else if (st_reg.mode) begin
            st_next.hs = main_on; // R6 R7
            st_next.ls = partner_on;
        end else begin
            st_next.hs = partner_on; // R6 R7
            st_next.ls = main_on;
        end

        // Register writes
        if (i_write) begin
            case (i_addr)
                ADR_CTRL:    st_next.ctrl_run = i_wdata[CTRL_RUN_BIT];
                ADR_DUTY:    st_next.duty     = i_wdata[CNT_W-1:0];
                ADR_SS_STEP: st_next.ss_step  = i_wdata[STEP_W-1:0];
                ADR_IRQ_MSK: st_next.irq_mask = i_wdata[IRQ_W-1:0];
                default:     st_next.ctrl_run = st_reg.ctrl_run;
            endcase
        end

        // Sticky events; a new event beats a simultaneous clear
        st_next.irq_st = (st_reg.irq_st & ~w1c) | events;

        // Register reads, answered in the next cycle
        if (i_read) begin
            case (i_addr)
                ADR_CTRL:    st_next.rdata = DATA_W'(st_reg.ctrl_run);
                ADR_DUTY:    st_next.rdata = DATA_W'(st_reg.duty);
                ADR_SS_STEP: st_next.rdata = DATA_W'(st_reg.ss_step);
                ADR_STATUS:  st_next.rdata = status_word;
                ADR_IRQ_ST:  st_next.rdata = DATA_W'(st_reg.irq_st);
                ADR_IRQ_MSK: st_next.rdata = DATA_W'(st_reg.irq_mask);
                default:     st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            st_reg          <= '0;
            st_reg.duty     <= DUTY_RST;
            st_reg.ss_step  <= SS_STEP_RST;
            st_reg.ctrl_run <= 1'b1;
        end else if (i_clock_en) begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs
    assign o_high_side_drive = st_reg.hs;
    assign o_low_side_drive  = st_reg.ls;
    assign o_rdata           = st_reg.rdata;
    assign o_irq             = |(st_reg.irq_st & st_reg.irq_mask);

    // ==========================================================
    // Assertions
    sequence dis_then_run_s;
        (!run && i_clock_en) ##1 (run && i_clock_en);
    endsequence

    sequence fresh_start_s;
        (st_reg.phase == PH_WAIT) && (st_reg.ss <= 13'h1);
    endsequence

    mode_hold_a: assert property (@(posedge i_clock) disable iff (i_reset) // R2
        (i_clock_en && run && st_reg.en_q && st_reg.fault_n_q) |=> $stable(st_reg.mode))
        else $error("mode changed while enabled");

    mode_track_a: assert property (@(posedge i_clock) disable iff (i_reset) // R4
        (i_clock_en && !run) |=> (st_reg.mode == $past(mode_s)))
        else $error("mode not following pin while disabled");

    drive_off_a: assert property (@(posedge i_clock) disable iff (i_reset) // R8
        (i_clock_en && !run) |=> (!o_high_side_drive && !o_low_side_drive))
        else $error("drive active while disabled");

    no_overlap_a: assert property (@(posedge i_clock) disable iff (i_reset) // R6
        !(o_high_side_drive && o_low_side_drive))
        else $error("both drives high");

    wait_quiet_a: assert property (@(posedge i_clock) disable iff (i_reset) // R12
        (i_clock_en && (st_reg.phase == PH_WAIT))
        |=> (!o_high_side_drive && !o_low_side_drive))
        else $error("drive active below first threshold");

    nonsync_one_a: assert property (@(posedge i_clock) disable iff (i_reset) // R13
        (i_clock_en && (st_reg.phase == PH_NONSYNC))
        |=> (st_reg.mode ? !o_low_side_drive : !o_high_side_drive))
        else $error("partner switch active in nonsynchronous phase");

    sync_enter_a: assert property (@(posedge i_clock) disable iff (i_reset) // R14
        (i_clock_en && run && (st_reg.phase == PH_NONSYNC) && (st_reg.ss > SS_TH2_MV))
        |=> (st_reg.phase == PH_SYNC))
        else $error("synchronous phase not entered");

    duty_limit_a: assert property (@(posedge i_clock) disable iff (i_reset) // R15
        (i_clock_en && (st_reg.cnt >= ramp_lim))
        |=> !(st_reg.mode ? o_high_side_drive : o_low_side_drive))
        else $error("main switch beyond ramp duty limit");

    lead_order_a: assert property (@(posedge i_clock) disable iff (i_reset) // R6
        (i_clock_en && run && (st_reg.phase == PH_SYNC) && (st_reg.cnt == '0) && (lim != '0))
        |=> (st_reg.mode ? o_high_side_drive : o_low_side_drive))
        else $error("wrong switch leads the period");

    ramp_reset_a: assert property (@(posedge i_clock) disable iff (i_reset) // R18
        (i_clock_en && !run) |=> (st_reg.ss == '0) && (st_reg.phase == PH_OFF))
        else $error("ramp not reset on disable");

    restart_a: assert property (@(posedge i_clock) disable iff (i_reset) // R16
        dis_then_run_s |=> fresh_start_s)
        else $error("no fresh soft start after re-enable");

endmodule : cdps_top
